// file: ahp_fifo.sv
// sample fifo with valid/ready on both sides
`timescale 1ns/1ns
module ahp_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem[rd_ptr_reg];
  assign level_o = count_reg;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  full_never_over_a: assert property (@(posedge clk_i) disable iff (rst_i)
    count_reg <= DEPTH[AW:0]) else $error("fifo count above depth");
endmodule : ahp_fifo

// file: ahp_host_model.sv
// host processor model for the converter parallel port
`timescale 1ns/1ns
module ahp_host_model (
  input wire logic clk_i,
  output ahp_pkg::ahp_bus_t bus_o,
  output logic [ahp_pkg::CTRL_W-1:0] data_o,
  input wire logic [ahp_pkg::CTRL_W-1:0] data_i,
  input wire logic data_oe_i
);
  import ahp_pkg::*;
  initial begin
    bus_o = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    data_o = 10'h3FF;
  end
  // chip_select_low_n drops after the strobe and rises before it, so the port starts and ends on the select
  task automatic access(input logic rd, input logic a, input logic [CTRL_W-1:0] d,
      input logic comb, input logic [1:0] cs, output logic [CTRL_W-1:0] q,
      output logic oe_on, output logic oe_off);
    @(posedge clk_i);
    bus_o.addr <= a;
    data_o <= d;
    // direction settles before the selects; the same level is the write strobe
    bus_o.wr_n <= rd;
    bus_o.rd_n <= comb ? 1'b1 : ~rd;
    @(posedge clk_i);
    {bus_o.chip_select_low_n, bus_o.chip_select_high} <= cs;
    repeat (2) @(posedge clk_i);
    q = data_i;
    oe_on = data_oe_i;
    bus_o.chip_select_low_n <= 1'b1;
    @(posedge clk_i);
    oe_off = data_oe_i;
    bus_o.chip_select_high <= 1'b0;
    bus_o.rd_n <= 1'b1;
    bus_o.wr_n <= 1'b1;
    data_o <= ~d;
    @(posedge clk_i);
  endtask : access
endmodule : ahp_host_model

// file: ahp_host_port.sv
// processor-side parallel port: strobe decode, control regs, data-available flag
`timescale 1ns/1ns
// Notes on behaviour
// - style bit 0 gives a static level flag, 1 gives a pulse.
// - polarity bit 0 makes the flag active low, 1 active high.
// - level style: flag goes active as soon as the watermark condition holds.
// - level style: flag drops at the start of the first watermark read.
// - level style: condition rechecked only after a full watermark of reads.
// - pulse style in continuous mode lasts half a conversion clock period.
// - access begins when the last qualifying input becomes valid.
// - without combined mode, write input is write strobe, read is read strobe.
// - a read access drives the flag inactive from last chip select valid.
// - internal strobe ends when the first qualifying input goes inactive.
// - combined mode: direction high is read, low is write.
// - two-bit field picks watermark 1,4,8,14 or 2,4,8,12 values.
// - write strobe loads the control registers; read strobe pops fifo words.
module ahp_host_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ahp_pkg::ahp_bus_t bus_i,
  input wire logic [ahp_pkg::CTRL_W-1:0] data_i,
  output logic [ahp_pkg::CTRL_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [ahp_pkg::DATA_W-1:0] sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic two_channels_i,
  input wire logic continuous_i,
  input wire logic conversion_clock_input_i,
  output logic fifo_ready_flag_o,
  output logic [ahp_pkg::CTRL_W-1:0] ctrl0_o,
  output logic [ahp_pkg::CTRL_W-1:0] ctrl1_o
);
  import ahp_pkg::*;

  logic [CTRL_W-1:0] ctrl0_reg;
  logic [CTRL_W-1:0] ctrl1_reg;
  logic selected;
  logic rd_int;
  logic wr_int;
  logic rd_int_reg;
  logic wr_int_reg;
  logic rd_start;
  logic wr_start;
  logic [DATA_W-1:0] fifo_data;
  logic fifo_valid;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic [CNT_W-1:0] watermark;
  logic [CNT_W-1:0] reads_left_reg;
  logic armed_reg;
  logic flag_reg;
  logic pulse_reg;
  logic conversion_clock_input_reg;
  logic conv_rise;
  logic [DATA_W-1:0] rd_data_reg;
  logic trigger;
  logic style_pulse;
  logic style_off;
  ahp_state_t state_reg;

  assign style_pulse = ctrl1_reg[STYLE_BIT];
  assign selected = !bus_i.chip_select_low_n && bus_i.chip_select_high;

  // combined mode reuses the write pin as direction, read pin is ignored
  always_comb begin
    if (ctrl1_reg[RW_BIT]) begin
      rd_int = selected && bus_i.wr_n;
      wr_int = selected && !bus_i.wr_n;
    end else begin
      rd_int = selected && !bus_i.rd_n && bus_i.wr_n;
      wr_int = selected && !bus_i.wr_n && bus_i.rd_n;
    end
  end

  // strobe begins on the last qualifier and ends on the first to drop
  assign rd_start = rd_int && !rd_int_reg;
  assign wr_start = wr_int && !wr_int_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_int_reg <= 1'b0;
      wr_int_reg <= 1'b0;
      state_reg <= AHP_IDLE;
    end else begin
      rd_int_reg <= rd_int;
      wr_int_reg <= wr_int;
      case (state_reg)
        AHP_IDLE: begin
          if (rd_start) begin
            state_reg <= AHP_READ;
          end else if (wr_start) begin
            state_reg <= AHP_WRITE;
          end
        end
        AHP_READ: begin
          if (!rd_int) begin
            state_reg <= AHP_IDLE;
          end
        end
        AHP_WRITE: begin
          if (!wr_int) begin
            state_reg <= AHP_IDLE;
          end
        end
        default: state_reg <= AHP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl0_reg <= CTRL0_RST;
      ctrl1_reg <= CTRL1_RST;
    end else if (wr_start) begin
      if (bus_i.addr == ADDR_CTRL1) begin
        ctrl1_reg <= data_i;
      end else begin
        ctrl0_reg <= data_i;
      end
    end
  end

  ahp_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(sample_i),
    .in_valid_i(sample_valid_i),
    .in_ready_o(sample_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(rd_start),
    .level_o(fifo_level)
  );

  // read word held for the whole strobe, bus driven only while selected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_reg <= '0;
    end else if (rd_start && fifo_valid) begin
      // an empty read repeats the last word instead of stale memory
      rd_data_reg <= fifo_data;
    end
  end
  assign data_o = rd_data_reg;
  assign data_oe_o = rd_int_reg && rd_int;

  always_comb begin
    case ({two_channels_i, ctrl1_reg[TRIG1_BIT], ctrl1_reg[TRIG0_BIT]})
      3'b000: watermark = WM1_0;
      3'b001: watermark = WM1_1;
      3'b010: watermark = WM1_2;
      3'b011: watermark = WM1_3;
      3'b100: watermark = WM2_0;
      3'b101: watermark = WM2_1;
      3'b110: watermark = WM2_2;
      default: watermark = WM2_3;
    endcase
  end
  assign trigger = (fifo_level >= {1'b0, watermark});

  // level style: disarmed while a watermark batch of reads is outstanding
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;
      armed_reg <= 1'b1;
      reads_left_reg <= '0;
    end else if (!armed_reg) begin
      if (rd_start) begin
        flag_reg <= 1'b0;
        if (reads_left_reg == 5'h01) begin
          armed_reg <= 1'b1;
        end
        reads_left_reg <= reads_left_reg - 1'b1;
      end
    end else if (trigger && !style_pulse) begin
      flag_reg <= 1'b1;
      armed_reg <= 1'b0;
      reads_left_reg <= watermark;
    end else begin
      flag_reg <= 1'b0;
    end
  end

  // pulse style: one half conversion clock, high phase after a trigger
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conversion_clock_input_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      conversion_clock_input_reg <= conversion_clock_input_i;
      // mode writes cut the pulse; a rising edge beats a read in one cycle
      if (!style_pulse || !continuous_i || style_off) begin
        pulse_reg <= 1'b0;
      end else if (conv_rise && trigger) begin
        pulse_reg <= 1'b1;
      end else if (rd_start || !conversion_clock_input_i) begin
        pulse_reg <= 1'b0;
      end
    end
  end
  assign conv_rise = conversion_clock_input_i && !conversion_clock_input_reg;
  assign style_off = wr_start && (bus_i.addr == ADDR_CTRL1) && !data_i[STYLE_BIT];

  // polarity inverts after style select, both styles share it
  assign fifo_ready_flag_o = (style_pulse ? pulse_reg : flag_reg) ~^ ctrl1_reg[POL_BIT];
  assign ctrl0_o = ctrl0_reg;
  assign ctrl1_o = ctrl1_reg;

  flag_drops_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!style_pulse && !armed_reg && rd_start) |=> !flag_reg) else $error("flag not cleared by read");
  flag_sets_trig_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (armed_reg && trigger && !style_pulse) |=> flag_reg) else $error("flag missed trigger");
  no_rearm_early_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!armed_reg && !rd_start) |=> !armed_reg) else $error("rearmed without read");
  polarity_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fifo_ready_flag_o == ((style_pulse ? pulse_reg : flag_reg) == ctrl1_reg[POL_BIT]))
    else $error("polarity wrong");
  pulse_half_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pulse_reg && !conversion_clock_input_i) |=> !pulse_reg) else $error("pulse outlived half period");
  level_no_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !style_pulse |-> !pulse_reg) else $error("pulse in level style");
  deselect_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !selected |-> !data_oe_o) else $error("bus driven while deselected");
  write_loads_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_start && bus_i.addr == ADDR_CTRL1) |=> ctrl1_reg == $past(data_i))
    else $error("control write lost");
  strobe_ends_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == AHP_READ && !rd_int) |=> state_reg == AHP_IDLE) else $error("strobe stuck");
  read_cov_c: cover property (@(posedge clk_i) rd_start && fifo_valid);
  write_cov_c: cover property (@(posedge clk_i) wr_start);
  pulse_cov_c: cover property (@(posedge clk_i) pulse_reg);
  rearm_cov_c: cover property (@(posedge clk_i) !armed_reg ##1 armed_reg);
endmodule : ahp_host_port

// file: ahp_host_port_tb.sv
// self-checking testbench for the converter host port
`timescale 1ns/1ns
module ahp_host_port_tb;
  import ahp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  ahp_bus_t bus;
  logic [CTRL_W-1:0] wdata, rdata, ctrl0, ctrl1, q;
  logic [DATA_W-1:0] smp = 10'h000;
  logic [DATA_W-1:0] seq = 10'h155;
  logic svalid = 1'b0, two_ch = 1'b0, cont = 1'b0, conv = 1'b0;
  logic oe, ready, flag, oe_on, oe_off;
  logic [CTRL_W-1:0] exp_q[$];
  int errors = 0;
  int comparisons = 0;
  int wm_tab[8] = '{1, 4, 8, 14, 2, 4, 8, 12};
  always #20 clk_i = ~clk_i;
  ahp_host_port uut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .data_i(wdata),
    .data_o(rdata), .data_oe_o(oe), .sample_i(smp), .sample_valid_i(svalid),
    .sample_ready_o(ready), .two_channels_i(two_ch), .continuous_i(cont),
    .conversion_clock_input_i(conv), .fifo_ready_flag_o(flag), .ctrl0_o(ctrl0), .ctrl1_o(ctrl1));
  ahp_host_model host (.clk_i(clk_i), .bus_o(bus), .data_o(wdata), .data_i(rdata),
    .data_oe_i(oe));
  task automatic chk(input string what, input logic [CTRL_W-1:0] e, input logic [CTRL_W-1:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic chk_bit(input string what, input logic e, input logic g);
    chk(what, {9'h000, e}, {9'h000, g});
  endtask : chk_bit
  task automatic wr(input logic a, input logic [CTRL_W-1:0] d, input logic comb,
      input logic [1:0] cs = 2'b01);
    host.access(1'b0, a, d, comb, cs, q, oe_on, oe_off);
  endtask : wr
  task automatic rd(input logic comb);
    host.access(1'b1, 1'b0, 10'h2AA, comb, 2'b01, q, oe_on, oe_off);
    chk("word", exp_q.pop_front(), q);
    chk_bit("drive", 1'b1, oe_on);
    chk_bit("release", 1'b0, oe_off);
  endtask : rd
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      smp <= seq;
      svalid <= 1'b1;
      exp_q.push_back(seq);
      seq = seq + 10'h0C7;
    end
    @(posedge clk_i);
    svalid <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : push
  task automatic chk_reset;
    chk("ctrl0", CTRL0_RST, ctrl0);
    chk("ctrl1", CTRL1_RST, ctrl1);
    chk_bit("flag", 1'b1, flag);
    chk_bit("oe", 1'b0, oe);
    chk_bit("ready", 1'b1, ready);
  endtask : chk_reset
  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_reset;
    // rows: channel mode, watermark field and polarity from the index
    for (int r = 0; r < 8; r++) begin
      two_ch <= r[2];
      wr(ADDR_CTRL1, {4'h0, r[0], 1'b0, r[1:0], 2'h0}, 1'b0);
      chk("ctrl1", {4'h0, r[0], 1'b0, r[1:0], 2'h0}, ctrl1);
      push(wm_tab[r] - 1);
      chk_bit("below", ~r[0], flag);
      push(1);
      chk_bit("at level", r[0], flag);
      for (int i = 0; i < wm_tab[r]; i++) begin
        rd(1'b0);
        if (i == 0) chk_bit("after read", ~r[0], flag);
      end
    end
    // full buffer, then drain; the flag rearms after the first twelve reads
    two_ch <= 1'b1;
    wr(ADDR_CTRL1, 10'h00C, 1'b0);
    push(32);
    chk_bit("full", 1'b0, ready);
    chk_bit("flag full", 1'b0, flag);
    for (int i = 0; i < 32; i++) begin
      rd(1'b0);
      if (i == 10) chk_bit("disarmed", 1'b1, flag);
      if (i == 11) chk_bit("rearmed", 1'b0, flag);
    end
    chk_bit("empty", 1'b1, ready);
    two_ch <= 1'b0;
    wr(ADDR_CTRL1, 10'h060, 1'b0);
    push(1);
    rd(1'b1);
    wr(1'b0, 10'h2C3, 1'b1);
    chk("ctrl0 comb", 10'h2C3, ctrl0);
    wr(1'b0, 10'h13C, 1'b1, 2'b00);
    chk("ctrl0 bad cs", 10'h2C3, ctrl0);
    host.access(1'b1, 1'b0, 10'h000, 1'b1, 2'b11, q, oe_on, oe_off);
    chk_bit("bad cs oe", 1'b0, oe_on);
    wr(ADDR_CTRL1, 10'h030, 1'b1);
    push(3);
    // conversion clock of eight system cycles; first period with conversion stopped
    for (int p = 0; p < 3; p++) begin
      cont <= (p != 0);
      conv <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk_bit("pulse high", p != 0, flag);
      @(posedge clk_i);
      conv <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk_bit("pulse low", 1'b0, flag);
      @(posedge clk_i);
    end
    // a read in the high phase must cut the pulse short
    conv <= 1'b1;
    rd(1'b0);
    chk_bit("pulse read", 1'b0, flag);
    conv <= 1'b0;
    cont <= 1'b0;
    rd(1'b0);
    rd(1'b0);
    wr(1'b0, 10'h0A5, 1'b0);
    chk("ctrl0 pre reset", 10'h0A5, ctrl0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_reset;
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    close_out;
  end
endmodule : ahp_host_port_tb

// file: ahp_pkg.sv
// package for the converter host port: control fields, watermarks, carriers
package ahp_pkg;
  localparam int DATA_W = 10;
  localparam int FIFO_DEPTH = 32;
  localparam int CTRL_W = 10;
  // control register 1 field positions
  localparam int TRIG0_BIT = 2;
  localparam int TRIG1_BIT = 3;
  localparam int STYLE_BIT = 4;
  localparam int POL_BIT = 5;
  localparam int RW_BIT = 6;
  localparam logic [CTRL_W-1:0] CTRL0_RST = 10'h000;
  localparam logic [CTRL_W-1:0] CTRL1_RST = 10'h000;
  localparam int CNT_W = 5;
  // watermark levels, one channel and two channels
  localparam logic [CNT_W-1:0] WM1_0 = 5'h01;
  localparam logic [CNT_W-1:0] WM1_1 = 5'h04;
  localparam logic [CNT_W-1:0] WM1_2 = 5'h08;
  localparam logic [CNT_W-1:0] WM1_3 = 5'h0E;
  localparam logic [CNT_W-1:0] WM2_0 = 5'h02;
  localparam logic [CNT_W-1:0] WM2_1 = 5'h04;
  localparam logic [CNT_W-1:0] WM2_2 = 5'h08;
  localparam logic [CNT_W-1:0] WM2_3 = 5'h0C;
  localparam logic ADDR_CTRL1 = 1'b1;

  typedef struct packed {
    logic chip_select_low_n;
    logic chip_select_high;
    logic rd_n;
    logic wr_n;
    logic addr;
  } ahp_bus_t;

  typedef enum logic [1:0] {
    AHP_IDLE = 2'b00,
    AHP_READ = 2'b01,
    AHP_WRITE = 2'b10
  } ahp_state_t;
endpackage : ahp_pkg
